/* File: include/csc_consts.vh */
// Purpose: constants for the clock and stop mode controller
// Assumes: 8-bit registers on a wishbone word each
// Notes: offsets are word indices, byte address is four times the index
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH
`define CSC_IDX_SC1 6'h38
`define CSC_IDX_SC2 6'h39
`define CSC_IDX_STAT 6'h3a
`define CSC_SC1_RESET 8'h00
`define CSC_SC2_RESET 8'h80
`define CSC_B_STOP 7
`define CSC_B_RELEASE_METHOD_SEL 6
`define CSC_B_RETURN_MODE_SEL 5
`define CSC_B_STOP_OUTPUT_HOLD 4
`define CSC_B_WUT_HI 3
`define CSC_B_WUT_LO 2
`define CSC_B_XEN 7
`define CSC_B_XTEN 6
`define CSC_B_SYSCK 5
`define CSC_B_IDLE 4
`define CSC_B_TGH 2
`define CSC_UNDEF_FILL 8'h00
`define CSC_WU_N00 20'h30000
`define CSC_WU_N01 20'h10000
`define CSC_WU_N10 20'h0c000
`define CSC_WU_N11 20'h04000
`define CSC_WU_S00 20'h06000
`define CSC_WU_S01 20'h02000
`define CSC_WU_S10 20'h000c0
`define CSC_WU_S11 20'h00040
`endif

/* File: rtl/csc_top.v */
// Purpose: system clock select, idle/sleep halts and stop mode sequencing
// Assumes: wishbone classic slave, one clk_i domain, synchronous rst_i
// Notes: oscillator ticks, wake and pin inputs arrive asynchronously
//
// What this block does
// - clock select bit picks clock, reads actual
// - reset when enables leave no clock
// - halt bit stops cpu and watchdog
// - gate bit stops peripheral clocks except timebase
// - sc2 bits 3,1,0 read undefined
// - deep halt exit timed asynchronously
// - halt bit self clears on release
// - gate bit self clears on release
// - stop bit write enters stop
// - stop turns oscillators off, state held
// - prescaler and divider cleared at stop
// - program counter held, resume next instruction
// - level release leaves stop when pin high
// - level release with pin high skips stop
// - edge to level switch waits rising edge
// - edge release needs rising edge
// - release restarts oscillators per return mode
// - warm-up interval holds internal operations halted
// - warm-up field selects cycle counts
// - return mode bit, reset pin returns normal
// - output hold bit decides port state
// - reset pin low ends stop at once
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "csc_consts.vh"
module csc_top #(
  parameter WU_W = 20
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire stop_pin_i,
  input wire reset_pin_n_i,
  input wire hf_tick_i,
  input wire lf_tick_i,
  input wire deep_wake_i,
  input wire halt_wake_i,
  input wire single_clock_i,
  output reg sys_reset_o,
  output reg clk_sel_low_o,
  output reg hf_osc_en_o,
  output reg lf_osc_en_o,
  output reg cpu_halt_o,
  output reg periph_gate_o,
  output reg div_clear_o,
  output reg port_hiz_o,
  output reg stop_active_o
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_RUN = 3'b001;
localparam ST_STOP = 3'b010;
localparam ST_WARM = 3'b100;
reg [2:0] state_reg;
reg [7:0] sc1_reg;
reg [7:0] sc2_reg;
reg sysck_act_reg;
reg release_method_sel_eff_reg;
reg [WU_W-1:0] wu_cnt_reg;
reg [WU_W-1:0] wu_term;
reg ret_slow_reg;
localparam N_SYNC = 6;
reg [N_SYNC-1:0] sync_a_reg;
reg [N_SYNC-1:0] sync_b_reg;
reg [N_SYNC-1:0] sync_c_reg;
reg pin_rst_d_reg;
// bit order: stop pin, reset pin, hf tick, lf tick, deep wake, halt wake
wire [N_SYNC-1:0] async_in = {halt_wake_i, deep_wake_i, lf_tick_i, hf_tick_i, reset_pin_n_i,
  stop_pin_i};
wire stop_lvl = sync_b_reg[0];
wire stop_rise = sync_b_reg[0] & ~sync_c_reg[0];
wire pin_rst = ~sync_b_reg[1];
wire hf_rise = sync_b_reg[2] & ~sync_c_reg[2];
wire lf_rise = sync_b_reg[3] & ~sync_c_reg[3];
wire deep_wake_s = sync_b_reg[4];
wire halt_wake_s = sync_b_reg[5];
wire osc_tick = ret_slow_reg ? lf_rise : hf_rise;
wire soft_rst = rst_i | pin_rst | sys_reset_o;
wire stop_busy = (state_reg != ST_RUN);
// oscillators that a release restarts, by return mode and clock system
wire hf_restart = ~ret_slow_reg;
wire lf_restart = ret_slow_reg | ~single_clock_i;
wire [WU_W-1:0] wu_cnt_next = wu_cnt_reg + {{(WU_W-1){1'b0}}, 1'b1};
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr_lo = wb_req & wb_we_i & wb_sel_i[0];
wire wr_sc1 = wr_lo & (wb_adr_i == `CSC_IDX_SC1);
wire wr_sc2 = wr_lo & (wb_adr_i == `CSC_IDX_SC2);
wire [7:0] d = wb_dat_i[7:0];
// clock loss check on the enables being written and the active clock
wire bad_clk = wr_sc2 & ((~d[`CSC_B_XEN] & ~d[`CSC_B_XTEN]) |
  (~d[`CSC_B_XEN] & ~sysck_act_reg) | (~d[`CSC_B_XTEN] & sysck_act_reg));
wire release_now = release_method_sel_eff_reg ? stop_lvl : stop_rise;
////////////////////////////////////////////////////////////////////////////////
always @*
begin
  case (sc1_reg[`CSC_B_WUT_HI:`CSC_B_WUT_LO])
    2'b00: wu_term = ret_slow_reg ? `CSC_WU_S00 : `CSC_WU_N00;
    2'b01: wu_term = ret_slow_reg ? `CSC_WU_S01 : `CSC_WU_N01;
    2'b10: wu_term = ret_slow_reg ? `CSC_WU_S10 : `CSC_WU_N10;
    default: wu_term = ret_slow_reg ? `CSC_WU_S11 : `CSC_WU_N11;
  endcase
end
////////////////////////////////////////////////////////////////////////////////
genvar gi;
generate
  for (gi = 0; gi < N_SYNC; gi = gi + 1)
  begin : g_sync
    // two flops before any use, a third only for edge detection
    always @(posedge clk_i)
    begin
      sync_a_reg[gi] <= async_in[gi];
      sync_b_reg[gi] <= sync_a_reg[gi];
      sync_c_reg[gi] <= sync_b_reg[gi];
    end
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// remembers the pin reset so that a held pin pulses the reset once
always @(posedge clk_i)
begin
  pin_rst_d_reg <= pin_rst;
end
////////////////////////////////////////////////////////////////////////////////
// one pulse per pin assertion, or one for a clock-losing write
always @(posedge clk_i)
begin
  if (rst_i)
    sys_reset_o <= 1'b0;
  else if (pin_rst)
    sys_reset_o <= ~pin_rst_d_reg;
  else if (sys_reset_o)
    sys_reset_o <= 1'b0;
  else
    sys_reset_o <= bad_clk;
end
////////////////////////////////////////////////////////////////////////////////
// level method applies only after a rising edge; edge applies at once
always @(posedge clk_i)
begin
  if (soft_rst)
    release_method_sel_eff_reg <= 1'b0;
  else if (~sc1_reg[`CSC_B_RELEASE_METHOD_SEL])
    release_method_sel_eff_reg <= 1'b0;
  else if (stop_rise)
    release_method_sel_eff_reg <= 1'b1;
end
////////////////////////////////////////////////////////////////////////////////
// warm-up counter: zero while running, counts restarted oscillator ticks
always @(posedge clk_i)
begin
  if (soft_rst)
    wu_cnt_reg <= {WU_W{1'b0}};
  else if (state_reg == ST_RUN)
    wu_cnt_reg <= {WU_W{1'b0}};
  else if ((state_reg == ST_WARM) & osc_tick)
    wu_cnt_reg <= wu_cnt_next;
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (soft_rst)
  begin
    state_reg <= ST_RUN;
    sc1_reg <= `CSC_SC1_RESET;
    sc2_reg <= `CSC_SC2_RESET;
    sysck_act_reg <= 1'b0;
    ret_slow_reg <= 1'b0;
  end
  else
  begin
    if (wr_sc2 & ~bad_clk)
    begin
      sc2_reg <= d;
      sysck_act_reg <= d[`CSC_B_SYSCK];
    end
    // release clears win over software writes
    if (sc2_reg[`CSC_B_IDLE] & halt_wake_s)
      sc2_reg[`CSC_B_IDLE] <= 1'b0;
    if (sc2_reg[`CSC_B_TGH] & deep_wake_s)
      sc2_reg[`CSC_B_TGH] <= 1'b0;
    if (wr_sc1)
      sc1_reg <= d & ~(8'h01 << `CSC_B_STOP);
    case (state_reg)
      ST_RUN:
      begin
        if (wr_sc1 & d[`CSC_B_STOP])
        begin
          ret_slow_reg <= d[`CSC_B_RETURN_MODE_SEL];
          if (release_method_sel_eff_reg & stop_lvl)
            state_reg <= ST_WARM;
          else
            state_reg <= ST_STOP;
        end
      end
      ST_STOP:
      begin
        if (release_now)
          state_reg <= ST_WARM;
      end
      ST_WARM:
      begin
        if (wu_cnt_reg >= wu_term)
        begin
          state_reg <= ST_RUN;
          sysck_act_reg <= ret_slow_reg;
          sc2_reg[`CSC_B_SYSCK] <= ret_slow_reg;
          // only the restarted oscillators stay enabled after return
          sc2_reg[`CSC_B_XEN] <= hf_restart;
          sc2_reg[`CSC_B_XTEN] <= lf_restart;
        end
      end
      default: state_reg <= ST_RUN;
    endcase
  end
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    clk_sel_low_o <= 1'b0;
  else
    clk_sel_low_o <= sysck_act_reg;
end
////////////////////////////////////////////////////////////////////////////////
// oscillators off in stop, restarted per return mode in warm-up
always @(posedge clk_i)
begin
  if (rst_i)
    hf_osc_en_o <= 1'b1;
  else if (state_reg == ST_STOP)
    hf_osc_en_o <= 1'b0;
  else if (state_reg == ST_WARM)
    hf_osc_en_o <= hf_restart;
  else
    hf_osc_en_o <= sc2_reg[`CSC_B_XEN];
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    lf_osc_en_o <= 1'b0;
  else if (state_reg == ST_STOP)
    lf_osc_en_o <= 1'b0;
  else if (state_reg == ST_WARM)
    lf_osc_en_o <= lf_restart;
  else
    lf_osc_en_o <= sc2_reg[`CSC_B_XTEN];
end
////////////////////////////////////////////////////////////////////////////////
// stop and warm-up keep the cpu halted as well as the halt bits
always @(posedge clk_i)
begin
  if (rst_i)
    cpu_halt_o <= 1'b0;
  else
    cpu_halt_o <= stop_busy | sc2_reg[`CSC_B_IDLE] | sc2_reg[`CSC_B_TGH];
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    periph_gate_o <= 1'b0;
  else
    periph_gate_o <= stop_busy | sc2_reg[`CSC_B_TGH];
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    div_clear_o <= 1'b0;
  else
    div_clear_o <= stop_busy;
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    port_hiz_o <= 1'b0;
  else
    port_hiz_o <= (state_reg == ST_STOP) & ~sc1_reg[`CSC_B_STOP_OUTPUT_HOLD];
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    stop_active_o <= 1'b0;
  else
    stop_active_o <= stop_busy;
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
    wb_ack_o <= 1'b0;
  else
    wb_ack_o <= wb_req;
end
////////////////////////////////////////////////////////////////////////////////
// read data stands until the next read
always @(posedge clk_i)
begin
  if (rst_i)
    wb_dat_o <= 32'h00000000;
  else
  begin
    if (wb_req & ~wb_we_i)
    begin
      if (wb_adr_i == `CSC_IDX_SC1)
        wb_dat_o <= {24'h000000, sc1_reg[7:2], 2'b00};
      else if (wb_adr_i == `CSC_IDX_SC2)
        wb_dat_o <= {24'h000000, sc2_reg[7:6], sysck_act_reg, sc2_reg[4], 1'b0,
          sc2_reg[2], 2'b00} | {24'h000000, `CSC_UNDEF_FILL};
      else if (wb_adr_i == `CSC_IDX_STAT)
        wb_dat_o <= {27'h0000000, release_method_sel_eff_reg, ret_slow_reg, state_reg == ST_WARM,
          state_reg == ST_STOP, sysck_act_reg};
      else
        wb_dat_o <= 32'h00000000;
    end
  end
end
endmodule // csc_top

/* File: tb/csc_assertions.sv */
// Purpose: port checker for csc_top
// Assumes: one clock, synchronous active-high rst_i
// Notes: bound to csc_top below the module
module csc_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire reset_pin_n_i,
  input wire halt_wake_i,
  input wire deep_wake_i,
  input wire sys_reset_o,
  input wire hf_osc_en_o,
  input wire lf_osc_en_o,
  input wire cpu_halt_o,
  input wire periph_gate_o,
  input wire stop_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // edge-release stop write acknowledged on this edge
  sequence s_wr_stop;
    wb_ack_o && wb_we_i && wb_adr_i == 6'h38 && wb_sel_i[0] && wb_dat_i[7:6] == 2'b10;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_stop_entry: assert property (s_wr_stop |=> stop_active_o)
    else $error("stop not entered");
  a_osc_off: assert property (s_wr_stop |=> !hf_osc_en_o && !lf_osc_en_o)
    else $error("oscillator on in stop");
  a_undef_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 6'h39 |->
    wb_dat_o[31:8] == 0 && wb_dat_o[3] == 0 && wb_dat_o[1:0] == 0) else $error("bad fill");
  a_pin_reset: assert property ($fell(reset_pin_n_i) |-> ##[1:4] sys_reset_o)
    else $error("no pin reset");
  a_halt_clear: assert property (halt_wake_i && cpu_halt_o |-> ##[1:4] !cpu_halt_o)
    else $error("halt kept");
  a_gate_clear: assert property (deep_wake_i && periph_gate_o |-> ##[1:4] !periph_gate_o)
    else $error("gate kept");
endmodule // csc_chk
bind csc_top csc_chk u_chk (.*);

/* File: tb/csc_wake_src.sv */
// Purpose: wake-up source on the stop pin
// Assumes: bench requests the pin level on kick_i
// Notes: pin changes only just after a clock edge
module csc_wake_src (
  input wire clk_i,
  input wire kick_i,
  output logic stop_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial stop_pin_o = 1'b0;
  always @(posedge clk_i)
    stop_pin_o <= kick_i;
endmodule // csc_wake_src

/* File: tb/testbench.sv */
// Purpose: self-checking bench for csc_top
// Assumes: wishbone classic, word index addressing
// Notes: slow return with shortest warm-up keeps the run brief
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rp_n = 1, hw = 0, dw = 0, kick = 0;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0, rd, q;
  logic [1:0] tk = 0;
  logic sc = 0;
  logic ack, srst, sel_lo, hfe, lfe, halt, gate, stp, pin, hiz, dvc;
  int n_mismatch = 0, n_checks = 0, m_sc2, n_srst = 0;
  csc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .stop_pin_i(pin), .reset_pin_n_i(rp_n), .hf_tick_i(tk[1]), .lf_tick_i(tk[1]),
    .deep_wake_i(dw), .halt_wake_i(hw), .single_clock_i(sc), .sys_reset_o(srst),
    .clk_sel_low_o(sel_lo), .hf_osc_en_o(hfe), .lf_osc_en_o(lfe), .cpu_halt_o(halt),
    .periph_gate_o(gate), .div_clear_o(dvc), .port_hiz_o(hiz), .stop_active_o(stp));
  csc_wake_src i_src (.clk_i(clk_i), .kick_i(kick), .stop_pin_o(pin));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) tk <= tk + 2'h1;
  // counts system reset pulses, which stand for one cycle only
  always @(posedge clk_i) if (srst === 1'b1) n_srst <= n_srst + 1;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk_i);
    q = rd;
    cyc <= 0;
    stb <= 0;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      end_sim();
    end
    @(posedge clk_i);
  endtask
  // 0 reset pulse, 1 stopped, 2 running, 3 halt and gate clear
  task automatic wt(input int w);
    int n;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge clk_i);
      if (w == 0 ? srst === 1'b1 : w == 3 ? (halt | gate) === 1'b0 : stp === (w == 1))
        break;
    end
    if (n == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask
  initial
  begin
    void'($urandom(32'hc6ac5065));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    m_sc2 = 'h80;
    bus(0, 6'h39, 0);
    chk(q, m_sc2);
    bus(1, 6'h10, $urandom);
    bus(0, 6'h10, 0);
    chk(q, 0);
    // halt and gate set in separate writes, peripherals idle
    for (int i = 0; i < 2; i++)
    begin
      bus(1, 6'h39, i ? 'h84 : 'h90);
      chk(i ? gate : halt, 1);
      hw <= !i;
      dw <= i;
      wt(3);
      hw <= 0;
      dw <= 0;
      bus(0, 6'h39, 0);
      chk(q, m_sc2);
    end
    // pin settles high before the stop write, so no edge is pending
    kick <= 1;
    bus(1, 6'h39, 'hc0);
    bus(1, 6'h38, 'hac);
    chk(stp, 1);
    kick <= 0;
    repeat (4) @(posedge clk_i);
    chk({hiz, dvc, stp}, 3'h7);
    kick <= 1;
    wt(2);
    chk({sel_lo, lfe, hfe}, 3'b110);
    bus(1, 6'h38, 'hac);
    rp_n <= 0;
    wt(0);
    rp_n <= 1;
    repeat (4) @(posedge clk_i);
    chk({stp, sel_lo, hiz, dvc}, 0);
    chk(n_srst, 1);
    bus(1, 6'h39, 0);
    repeat (2) @(posedge clk_i);
    chk(n_srst, 2);
    m_sc2 = 'h80;
    bus(0, 6'h39, 0);
    chk(q, m_sc2);
    // single clock system, normal return: only the fast oscillator restarts
    sc <= 1;
    bus(1, 6'h38, 'h8c);
    kick <= 0;
    repeat (4) @(posedge clk_i);
    kick <= 1;
    repeat (8) @(posedge clk_i);
    chk({lfe, hfe, stp}, 3'b011);
    rp_n <= 0;
    wt(0);
    rp_n <= 1;
    repeat (4) @(posedge clk_i);
    chk(stp, 0);
    chk(n_srst, 3);
    end_sim();
  end
endmodule // testbench
